// *** ihb_regs.svh ***
// Named constants for the bus cycle sequencer: status codes, counts and pin levels
`ifndef IHB_REGS_SVH
`define IHB_REGS_SVH

// Bus cycle status codes presented on the three status pins
`define IHB_STAT_INTACK    3'h0
`define IHB_STAT_RD_IO     3'h1
`define IHB_STAT_WR_IO     3'h2
`define IHB_STAT_HALT      3'h3
`define IHB_STAT_PREFETCH  3'h4
`define IHB_STAT_RD_MEM    3'h5
`define IHB_STAT_WR_MEM    3'h6
`define IHB_STAT_PASSIVE   3'h7

// Idle bus states spent in halt before the powerdown/idle pin park
`define IHB_HALT_SETTLE    3'h3

// Upper nibble driven in halt when the previous cycle left bit 3 set
`define IHB_HALT_NIBBLE    4'h8
`define IHB_NIBBLE_ZERO    4'h0
`define IHB_NIBBLE_MSB     3

// Reset values and byte lane boundaries
`define IHB_AD_ZERO        16'h0000
`define IHB_AD_ALL         16'hffff
`define IHB_AD_LOW_ONLY    16'h00ff
`define IHB_BYTE_ZERO      8'h00
`define IHB_VEC_LSB        0
`define IHB_VEC_MSB        7
`define IHB_ADDR_NIB_LSB   16
`define IHB_ADDR_BYTE_LSB  8

`endif

// *** ihb_pkg.sv ***
// Types shared by the bus cycle sequencer and its helpers
package ihb_pkg;

   // Kind of bus cycle the core asks for
   typedef enum logic [2:0] {
      IHB_RD_IO    = 3'h0,
      IHB_PREFETCH = 3'h1,
      IHB_RD_MEM   = 3'h2,
      IHB_WR_IO    = 3'h3,
      IHB_WR_MEM   = 3'h4,
      IHB_INTACK   = 3'h5,
      IHB_HALT     = 3'h6,
      IHB_REFRESH  = 3'h7
   } ihb_kind_type;

   // Bus T-states; Gray steps along idle, T1, T2, T3, T4
   typedef enum logic [2:0] {
      IHB_TI   = 3'h0,
      IHB_T1   = 3'h1,
      IHB_T2   = 3'h3,
      IHB_T3   = 3'h2,
      IHB_T4   = 3'h6,
      IHB_TW   = 3'h7,
      IHB_HLT  = 3'h4,
      IHB_HOLD = 3'h5
   } ihb_state_type;

endpackage

// *** ihb_cs_if.sv ***
// Signals between the sequencer and the chip-select unit
`timescale 1ns/100ps
interface ihb_cs_if #(parameter int ADDR_W = 20);
   logic [ADDR_W-1:0] addr;
   logic              mem_cycle;
   logic              cycle_active;
   logic              inhibit;
   logic              select_n;

   modport seq (output addr, output mem_cycle, output cycle_active, output inhibit,
                input select_n);
   modport cs  (input addr, input mem_cycle, input cycle_active, input inhibit,
                output select_n);
endinterface

// *** ihb_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ihb_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// *** ihb_chip_select.sv ***
// Low memory chip-select, kept quiet in halt and acknowledge cycles
`timescale 1ns/100ps
module ihb_chip_select #(
   parameter int        ADDR_W    = 20,
   parameter bit [19:0] LOW_LIMIT = 20'h04000
) (
   // Sequencer side
   ihb_cs_if.cs cs_bus
);
   logic in_range;

   // Window decode of the low memory block
   assign in_range = (cs_bus.addr < LOW_LIMIT[ADDR_W-1:0]);

   assign cs_bus.select_n = !(cs_bus.cycle_active && cs_bus.mem_cycle && in_range
                              && !cs_bus.inhibit);
endmodule

// *** ihb_bus_unit.sv ***
// Bus cycle sequencer: write, interrupt acknowledge and halt cycles
// Operation
// - Wait states stretch write cycle and strobe; recovery and hold stay fixed.
// - Interrupt acknowledge runs as two back-to-back read-shaped cycles.
// - Bus lock asserted across both acknowledge cycles.
// - Acknowledge strobe replaces read strobe in acknowledge cycles.
// - Second acknowledge captures vector from low byte lanes only.
// - In acknowledge, bits 15:13 carry cascade address, bits 12:8 float.
// - Cascade mode with control block at zero ignores external ready in acknowledge cycles.
// - Latch pulse in both acknowledge cycles, but no valid address.
// - During acknowledge latch pulse, AD lanes float; top nibble drives zero, address byte drives.
// - Halt suspends execution and runs one halt bus cycle.
// - Bus stays halted until interrupt; hold or refresh wake unless powerdown.
// - Halt T1 floats or drives the bus per previous cycle; floats after prefetch.
// - Halt right after a write keeps driving the bus during T1.
// - Top nibble keeps previous value in halt T1, then shows 8H if bit 3 was set, else zero.
// - Halt pin behaviour is the same for the same instruction sequence.
// - Chip-selects stay inactive in halt; external decoders disabled too.
// - Powerdown or idle halt parks pins low, controls inactive, byte-high one.
// - Plain halt floats bus, drives address byte, nibble 8H or zero.
// - Refresh or hold leaves halt briefly only in active or idle mode.
// - Returning to halt regenerates neither latch pulse nor halt status.
`timescale 1ns/100ps
`include "ihb_regs.svh"
module ihb_bus_unit #(
   parameter int        ADDR_W    = 20,
   parameter int        DATA_W    = 16,
   parameter bit [19:0] LOW_LIMIT = 20'h04000
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Core request and answer
   input  wire logic                 req_valid_i,
   input  wire ihb_pkg::ihb_kind_type req_kind_i,
   input  wire logic [ADDR_W-1:0]    req_addr_i,
   input  wire logic [DATA_W-1:0]    req_wdata_i,
   input  wire logic                 req_byte_high_i,
   output logic                      req_ready_o,
   output logic                      done_o,
   output logic [DATA_W-1:0]         rdata_o,
   output logic [7:0]                vector_o,
   output logic                      vector_valid_o,
   output logic                      halted_o,
   // Wakeup sources
   input  wire logic                 irq_i,
   input  wire logic                 refresh_req_i,
   input  wire logic [ADDR_W-1:0]    refresh_addr_i,
   input  wire logic                 hold_req_i,
   output logic                      hold_ack_o,
   // Configuration
   input  wire logic                 bus16_i,
   input  wire logic                 powerdown_en_i,
   input  wire logic                 idle_en_i,
   input  wire logic                 cascade_mode_i,
   input  wire logic                 pcb_at_zero_i,
   // Bus pins
   input  wire logic [DATA_W-1:0]    muxed_addr_data_i,
   output logic [DATA_W-1:0]         muxed_addr_data_o,
   output logic [DATA_W-1:0]         muxed_addr_data_oe_o,
   output logic [3:0]                upper_addr_status_o,
   output logic [7:0]                upper_addr_byte_o,
   output logic [2:0]                cycle_status_o,
   output logic                      ale_o,
   output logic                      rd_n_o,
   output logic                      wr_n_o,
   output logic                      int_ack_strobe_n_o,
   output logic                      data_enable_n_o,
   output logic                      data_direction_o,
   output logic                      lock_n_o,
   output logic                      byte_high_enable_n_o,
   output logic                      refresh_flag_n_o,
   output logic                      low_mem_select_n_o,
   input  wire logic                 bus_ready_i
);
   import ihb_pkg::*;

   ihb_state_type     state;
   ihb_state_type     next_state;
   ihb_kind_type      kind;
   ihb_kind_type      next_kind;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] ad_q;
   logic [3:0]        nibble_q;
   logic              bhe_n_q;
   logic              last_write;
   logic              ack_second;
   logic              halted;
   logic [2:0]        halt_cnt;
   logic              ready_sync;
   logic              hold_sync;
   logic [DATA_W-1:0] ad_sync;

   ihb_cs_if #(.ADDR_W(ADDR_W)) cs_bus ();

   // Pin inputs cross through two flops before any decode
   ihb_sync #(.WIDTH(2)) u_ctl_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i ({bus_ready_i, hold_req_i}),
      .sync_o  ({ready_sync, hold_sync})
   );
   ihb_sync #(.WIDTH(DATA_W)) u_data_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .async_i (muxed_addr_data_i),
      .sync_o  (ad_sync)
   );

   // Status code of a cycle kind, used only for the status pins
   function automatic logic [2:0] status_of(input ihb_kind_type k);
      case (k)
         IHB_RD_IO:    status_of = `IHB_STAT_RD_IO;
         IHB_PREFETCH: status_of = `IHB_STAT_PREFETCH;
         IHB_RD_MEM:   status_of = `IHB_STAT_RD_MEM;
         IHB_REFRESH:  status_of = `IHB_STAT_RD_MEM;
         IHB_WR_IO:    status_of = `IHB_STAT_WR_IO;
         IHB_WR_MEM:   status_of = `IHB_STAT_WR_MEM;
         IHB_INTACK:   status_of = `IHB_STAT_INTACK;
         IHB_HALT:     status_of = `IHB_STAT_HALT;
         default:      status_of = `IHB_STAT_PASSIVE;
      endcase
   endfunction

   // Cycle classification
   logic is_write;
   logic is_read;
   logic is_ack;
   logic is_halt;
   logic is_io;
   logic in_cycle;
   logic strobe_phase;
   logic low_power;
   logic parked;
   logic wake_ok;
   logic ready_go;
   logic [DATA_W-1:0] lane_mask;

   assign is_write     = (kind == IHB_WR_IO) || (kind == IHB_WR_MEM);
   assign is_ack       = (kind == IHB_INTACK);
   assign is_halt      = (kind == IHB_HALT);
   assign is_io        = (kind == IHB_RD_IO) || (kind == IHB_WR_IO);
   assign is_read      = !is_write && !is_ack && !is_halt;
   assign in_cycle     = (state == IHB_T1) || (state == IHB_T2) || (state == IHB_T3)
                         || (state == IHB_TW) || (state == IHB_T4);
   assign strobe_phase = (state == IHB_T2) || (state == IHB_T3) || (state == IHB_TW);
   assign low_power    = powerdown_en_i || idle_en_i;
   assign parked       = (state == IHB_HLT) && low_power && (halt_cnt == `IHB_HALT_SETTLE);
   assign wake_ok      = !powerdown_en_i;
   assign ready_go     = ready_sync || (is_ack && cascade_mode_i && pcb_at_zero_i);
   assign lane_mask    = bus16_i ? `IHB_AD_ALL : `IHB_AD_LOW_ONLY;

   // Next state and cycle kind
   always_comb begin
      next_state = state;
      next_kind  = kind;
      case (state)
         IHB_TI: begin
            if (refresh_req_i) begin
               next_state = IHB_T1;
               next_kind  = IHB_REFRESH;
            end else if (req_valid_i) begin
               next_state = IHB_T1;
               next_kind  = req_kind_i;
            end
         end
         IHB_T1: begin
            next_state = is_halt ? IHB_HLT : IHB_T2;
         end
         IHB_T2: next_state = IHB_T3;
         IHB_T3, IHB_TW: next_state = ready_go ? IHB_T4 : IHB_TW;
         IHB_T4: begin
            if (is_ack && !ack_second) begin
               next_state = IHB_T1;
            end else if (halted) begin
               // back to halt, no new halt cycle
               next_state = IHB_HLT;
            end else begin
               next_state = IHB_TI;
            end
         end
         IHB_HLT: begin
            if (irq_i) begin
               next_state = IHB_TI;
            end else if (wake_ok && hold_sync) begin
               next_state = IHB_HOLD;
            end else if (wake_ok && refresh_req_i) begin
               next_state = IHB_T1;
               next_kind  = IHB_REFRESH;
            end
         end
         IHB_HOLD: begin
            if (!hold_sync) begin
               next_state = IHB_HLT;
            end
         end
         default: next_state = IHB_TI;
      endcase
   end

   // State, cycle kind and halt bookkeeping
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state      <= IHB_TI;
         kind       <= IHB_PREFETCH;
         halted     <= 1'b0;
         ack_second <= 1'b0;
         halt_cnt   <= '0;
      end else begin
         state <= next_state;
         kind  <= next_kind;
         if (state == IHB_TI && next_state == IHB_T1 && next_kind == IHB_HALT) begin
            halted <= 1'b1;
         end else if (state == IHB_HLT && irq_i) begin
            halted <= 1'b0;
         end
         if (state == IHB_T4 && is_ack) begin
            ack_second <= !ack_second;
         end
         if (state != IHB_HLT) begin
            halt_cnt <= '0;
         end else if (halt_cnt != `IHB_HALT_SETTLE) begin
            halt_cnt <= halt_cnt + 3'h1;
         end
      end
   end

   // Request latches and last-driven bus values
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         addr_q     <= '0;
         wdata_q    <= '0;
         ad_q       <= `IHB_AD_ZERO;
         nibble_q   <= `IHB_NIBBLE_ZERO;
         bhe_n_q    <= 1'b1;
         last_write <= 1'b0;
      end else begin
         if (state == IHB_TI && next_state == IHB_T1) begin
            addr_q  <= (next_kind == IHB_REFRESH) ? refresh_addr_i : req_addr_i;
            wdata_q <= req_wdata_i;
            bhe_n_q <= (next_kind == IHB_REFRESH) ? 1'b1 : !req_byte_high_i;
         end else if (state == IHB_HLT && next_state == IHB_T1) begin
            addr_q  <= refresh_addr_i;
            bhe_n_q <= 1'b1;
         end
         if (muxed_addr_data_oe_o != `IHB_AD_ZERO) begin
            ad_q <= muxed_addr_data_o;
         end
         // nibble remembered from last real cycle
         if (state == IHB_T1 && !is_halt) begin
            nibble_q <= upper_addr_status_o;
         end
         if (state == IHB_T4) begin
            last_write <= is_write;
         end
      end
   end

   // Read data, vector and completion pulses
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o        <= '0;
         vector_o       <= `IHB_BYTE_ZERO;
         vector_valid_o <= 1'b0;
         done_o         <= 1'b0;
      end else begin
         vector_valid_o <= 1'b0;
         done_o         <= 1'b0;
         if (state == IHB_T4 && is_read && kind != IHB_REFRESH) begin
            rdata_o <= ad_sync;
         end
         if (state == IHB_T4 && is_ack && ack_second) begin
            vector_o       <= ad_sync[`IHB_VEC_MSB:`IHB_VEC_LSB];
            vector_valid_o <= 1'b1;
         end
         if (state == IHB_T4 && kind != IHB_REFRESH && !(is_ack && !ack_second)) begin
            done_o <= 1'b1;
         end
         if (state == IHB_T1 && is_halt) begin
            done_o <= 1'b1;
         end
      end
   end

   // Core handshake and suspension
   assign req_ready_o = (state == IHB_TI) && !halted && !refresh_req_i;
   assign halted_o    = halted;
   assign hold_ack_o  = (state == IHB_HOLD);

   assign ale_o          = (state == IHB_T1);
   assign cycle_status_o = ((state == IHB_T1) || (state == IHB_T2)) ? status_of(kind)
                           : `IHB_STAT_PASSIVE;

   assign rd_n_o             = !(strobe_phase && is_read);
   assign int_ack_strobe_n_o = !(strobe_phase && is_ack);
   // strobe rises at T4 regardless of waits
   assign wr_n_o             = !(strobe_phase && is_write);
   assign data_enable_n_o    = !(in_cycle && !is_halt && (strobe_phase
                                 || (state == IHB_T4 && is_write)));
   assign data_direction_o   = !(in_cycle && (is_read || is_ack));
   assign lock_n_o           = !(in_cycle && is_ack);

   // Address/data drive and float
   always_comb begin
      muxed_addr_data_o    = ad_q;
      muxed_addr_data_oe_o = `IHB_AD_ZERO;
      case (state)
         IHB_T1: begin
            if (is_ack) begin
               muxed_addr_data_oe_o = `IHB_AD_ZERO;
            end else if (is_halt) begin
               // depends only on the last cycle
               muxed_addr_data_oe_o = last_write ? lane_mask : `IHB_AD_ZERO;
            end else begin
               muxed_addr_data_o    = addr_q[DATA_W-1:0];
               muxed_addr_data_oe_o = lane_mask;
            end
         end
         IHB_T2, IHB_T3, IHB_TW, IHB_T4: begin
            // acknowledge cycles leave upper lanes floating
            if (is_write) begin
               muxed_addr_data_o    = wdata_q;
               muxed_addr_data_oe_o = lane_mask;
            end
         end
         IHB_TI: begin
            muxed_addr_data_oe_o = last_write ? lane_mask : `IHB_AD_ZERO;
         end
         IHB_HLT: begin
            muxed_addr_data_o    = `IHB_AD_ZERO;
            muxed_addr_data_oe_o = parked ? lane_mask : `IHB_AD_ZERO;
         end
         default: muxed_addr_data_oe_o = `IHB_AD_ZERO;
      endcase
   end

   // Upper address pins, byte-high enable and refresh flag
   logic [3:0] nibble_addr;
   logic [3:0] halt_nibble;

   assign nibble_addr = (is_io || is_ack) ? `IHB_NIBBLE_ZERO
                        : addr_q[`IHB_ADDR_NIB_LSB +: 4];
   assign halt_nibble = nibble_q[`IHB_NIBBLE_MSB] ? `IHB_HALT_NIBBLE : `IHB_NIBBLE_ZERO;

   assign upper_addr_status_o  = (in_cycle && !is_halt) ? nibble_addr
                                 : (parked ? `IHB_NIBBLE_ZERO
                                 : ((state == IHB_HLT) ? halt_nibble : nibble_q));
   assign upper_addr_byte_o    = parked ? `IHB_BYTE_ZERO
                                 : addr_q[`IHB_ADDR_BYTE_LSB +: 8];
   assign byte_high_enable_n_o = parked ? 1'b1 : bhe_n_q;
   assign refresh_flag_n_o     = !(in_cycle && kind == IHB_REFRESH && !bus16_i);

   // Chip-select unit
   assign cs_bus.addr         = addr_q;
   assign cs_bus.mem_cycle    = (kind == IHB_RD_MEM) || (kind == IHB_WR_MEM)
                                || (kind == IHB_PREFETCH);
   assign cs_bus.cycle_active = in_cycle;
   assign cs_bus.inhibit      = is_halt || is_ack || (state == IHB_HLT);
   assign low_mem_select_n_o  = cs_bus.select_n;

   ihb_chip_select #(
      .ADDR_W    (ADDR_W),
      .LOW_LIMIT (LOW_LIMIT)
   ) u_cs (
      .cs_bus (cs_bus.cs)
   );

endmodule

// *** ihb_bus_unit_assertions.sv ***
// Pin-level checks for the bus cycle sequencer
`timescale 1ns/100ps
module ihb_bus_unit_assertions (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        reset_i,
   // Watched pins
   input wire logic        halted_o,
   input wire logic        ale_o,
   input wire logic        rd_n_o,
   input wire logic        wr_n_o,
   input wire logic        int_ack_strobe_n_o,
   input wire logic        data_enable_n_o,
   input wire logic        lock_n_o,
   input wire logic        low_mem_select_n_o,
   input wire logic [2:0]  cycle_status_o,
   input wire logic [3:0]  upper_addr_status_o,
   input wire logic [15:0] muxed_addr_data_o,
   input wire logic [15:0] muxed_addr_data_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // First state of one acknowledge cycle
   sequence ack_t1;
      ale_o && cycle_status_o == 3'h0 && !lock_n_o;
   endsequence
   // Second acknowledge follows, waits allowed
   sequence second_ack;
      ##[4:40] ack_t1;
   endsequence
   ack_pair_a: assert property ($fell(lock_n_o) ##0 ack_t1 |-> second_ack)
      else $error("no second ack");
   ack_lock_a: assert property (ack_t1 |-> (!lock_n_o && rd_n_o) [*4])
      else $error("ack lock or strobe bad");
   ack_float_a: assert property (ack_t1 |-> !muxed_addr_data_oe_o && !upper_addr_status_o)
      else $error("ack address driven");
   write_pulse_a: assert property ($fell(wr_n_o) |-> !wr_n_o [*2])
      else $error("write strobe too short");
   write_hold_a: assert property ($rose(wr_n_o) |-> !data_enable_n_o
      && $stable(muxed_addr_data_o) ##1 muxed_addr_data_oe_o != 16'h0)
      else $error("write data not held");
   halt_status_a: assert property ($rose(cycle_status_o == 3'h3) |-> ale_o)
      else $error("halt status, no ale");
   halt_once_a: assert property (ale_o && cycle_status_o == 3'h3 |-> !$past(halted_o))
      else $error("halt cycle repeated");
   halt_cs_a: assert property (cycle_status_o == 3'h3 |-> low_mem_select_n_o)
      else $error("select in halt");
endmodule

// *** ihb_far_side.sv ***
// Far-side model: memory, peripherals and a cascaded interrupt controller
`timescale 1ns/100ps
module ihb_far_side (
   // Clock and pins seen from the far side
   input  wire logic        clk_i,
   input  wire logic        ale_i,
   input  wire logic        rd_n_i,
   input  wire logic        int_ack_strobe_n_i,
   output logic [15:0]      muxed_addr_data_o,
   output logic             bus_ready_o,
   // Bench controls: wait states and answers
   input  wire logic [3:0]  waits_i,
   input  wire logic [15:0] rdata_i,
   input  wire logic [7:0]  vector_i
);
   logic [7:0]  since_ale = 8'hff;
   logic [15:0] last = 16'h0000;
   // Cycles since latch pulse; last lane value
   always @(posedge clk_i) begin
      since_ale <= ale_i ? 8'h01 : since_ale + {7'h00, since_ale != 8'hff};
      last      <= muxed_addr_data_o;
   end
   assign bus_ready_o = ale_i ? (waits_i == 4'h0) : (since_ale >= {4'h0, waits_i});
   // no decoding; released lanes show the inverse
   assign muxed_addr_data_o = !int_ack_strobe_n_i ? {3'h5, ~last[12:8], vector_i}
                            : !rd_n_i ? rdata_i : ~last;
endmodule

// *** ihb_bus_unit_tb.sv ***
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/100ps
module ihb_bus_unit_tb;
   import ihb_pkg::*;
   // Bench inputs, defined from time zero
   logic         clk_i = 1'b0, reset_i = 1'b1, req_valid_i = 1'b0, req_byte_high_i = 1'b1;
   logic         irq_i = 1'b0, refresh_req_i = 1'b0, hold_req_i = 1'b0, bus16_i = 1'b1;
   logic         powerdown_en_i = 1'b0, idle_en_i = 1'b0, cascade_mode_i = 1'b0;
   logic         pcb_at_zero_i = 1'b0;
   logic [19:0]  req_addr_i = 20'h0, refresh_addr_i = 20'hf0001;
   logic [15:0]  req_wdata_i = 16'h0, far_rdata = 16'h5aa5, halt_oe;
   logic [7:0]   far_vector = 8'h00;
   logic [3:0]   waits = 4'h0;
   ihb_kind_type req_kind_i = IHB_RD_MEM;
   ihb_kind_type kinds [5] = '{IHB_RD_IO, IHB_PREFETCH, IHB_RD_MEM, IHB_WR_IO, IHB_WR_MEM};
   // Design outputs and far-side answers
   logic         req_ready_o, done_o, vector_valid_o, halted_o, hold_ack_o, ale_o, bus_ready_i;
   logic         rd_n_o, wr_n_o, int_ack_strobe_n_o, data_enable_n_o, data_direction_o, lock_n_o;
   logic         byte_high_enable_n_o, refresh_flag_n_o, low_mem_select_n_o;
   logic [15:0]  muxed_addr_data_i, muxed_addr_data_o, muxed_addr_data_oe_o, rdata_o;
   logic [7:0]   vector_o, upper_addr_byte_o;
   logic [3:0]   upper_addr_status_o;
   logic [2:0]   cycle_status_o;
   int           bad_count = 0, total_checks = 0, n, wr_low, rd_low, ale_cnt;
   // Halt pin group: nibble, byte, bhe_n, rd_n, wr_n, den_n, direction, status
   wire [19:0]   pins = {upper_addr_status_o, upper_addr_byte_o, byte_high_enable_n_o, rd_n_o,
                         wr_n_o, data_enable_n_o, data_direction_o, cycle_status_o};

   ihb_bus_unit DUT (
      .clk_i, .reset_i, .req_valid_i, .req_kind_i, .req_addr_i, .req_wdata_i, .req_byte_high_i,
      .req_ready_o, .done_o, .rdata_o, .vector_o, .vector_valid_o, .halted_o, .irq_i,
      .refresh_req_i, .refresh_addr_i, .hold_req_i, .hold_ack_o, .bus16_i, .powerdown_en_i,
      .idle_en_i, .cascade_mode_i, .pcb_at_zero_i, .muxed_addr_data_i, .muxed_addr_data_o,
      .muxed_addr_data_oe_o, .upper_addr_status_o, .upper_addr_byte_o, .cycle_status_o, .ale_o,
      .rd_n_o, .wr_n_o, .int_ack_strobe_n_o, .data_enable_n_o, .data_direction_o, .lock_n_o,
      .byte_high_enable_n_o, .refresh_flag_n_o, .low_mem_select_n_o, .bus_ready_i);

   ihb_far_side u_far (.clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o),
      .int_ack_strobe_n_i(int_ack_strobe_n_o), .waits_i(waits), .rdata_i(far_rdata),
      .vector_i(far_vector),
      .muxed_addr_data_o(muxed_addr_data_i), .bus_ready_o(bus_ready_i));

   // Clock, 100 ns period
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   // Event counters sampled mid-cycle, where pins have settled
   always @(negedge clk_i) begin
      if (!wr_n_o) wr_low++;
      if (!rd_n_o) rd_low++;
      if (ale_o) ale_cnt++;
      if (ale_o && cycle_status_o === 3'h3) halt_oe = muxed_addr_data_oe_o;
   end

   // Compare a pin value, then an event count
   task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_cnt(input string what, input int exp, input int got);
      total_checks++;
      if (got != exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Clear counters; halt drive unknown until seen
   task automatic clr();
      @(posedge clk_i);
      wr_low = 0;
      rd_low = 0;
      ale_cnt = 0;
      halt_oe = 'x;
   endtask

   // One core request held until taken; n counts cycles to done
   task automatic run(input ihb_kind_type k, input logic [19:0] a, input logic [15:0] d);
      @(posedge clk_i);
      req_kind_i  <= k;
      req_addr_i  <= a;
      req_wdata_i <= d;
      req_valid_i <= 1'b1;
      do @(negedge clk_i); while (req_ready_o !== 1'b1);
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 60);
   endtask

   // Interrupt ends the halt
   task automatic leave_halt();
      @(posedge clk_i);
      irq_i <= 1'b1;
      do @(negedge clk_i); while (halted_o !== 1'b0);
      @(posedge clk_i);
      irq_i <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      // Writes with zero to two waits
      for (int w = 0; w < 3; w++) begin
         waits <= w[3:0];
         clr();
         run(IHB_WR_MEM, 20'h8a5c3, 16'hc3a5);
         chk_cnt("write length", 5 + w, n);
         chk_cnt("write strobe", 2 + w, wr_low);
      end
      $display("test writes done");
      // Acknowledge pairs; waits ignored in cascade with block at zero
      for (int c = 0; c < 3; c++) begin
         waits          <= (c == 0) ? 4'h0 : 4'h1;
         cascade_mode_i <= (c == 2);
         pcb_at_zero_i  <= (c == 2);
         far_vector     <= 8'h3c + 8'(c);
         clr();
         run(IHB_INTACK, 20'h0, 16'h0);
         chk_cnt("ack length", (c == 1) ? 11 : 9, n);
         chk_val("vector", 20'h0003c + 20'(c), 20'(vector_o));
         chk_cnt("ack latch pulses", 2, ale_cnt);
         chk_cnt("ack read strobe", 0, rd_low);
      end
      waits <= 4'h0;
      $display("test acknowledge done");
      // Halt T1 drives the bus only after a write
      foreach (kinds[i]) begin
         clr();
         run(kinds[i], 20'h8a5c3, 16'h0ff0);
         run(IHB_HALT, 20'h8a5c3, 16'h0);
         chk_cnt("halt length", 2, n);
         chk_val("halt drive", 20'(kinds[i] inside {IHB_WR_IO, IHB_WR_MEM}), 20'(|halt_oe));
         leave_halt();
      end
      $display("test halt kinds done");
      // Plain halt pins, then refresh returns without a new halt cycle
      run(IHB_WR_MEM, 20'h8a5c3, 16'h1234);
      run(IHB_HALT, 20'h8a5c3, 16'h0);
      clr();
      @(negedge clk_i);
      chk_val("halt float", 20'h0, 20'(muxed_addr_data_oe_o));
      chk_val("halt pins", 20'h8a57f, pins);
      @(posedge clk_i);
      refresh_req_i <= 1'b1;
      @(posedge clk_i);
      refresh_req_i <= 1'b0;
      repeat (10) @(negedge clk_i);
      chk_cnt("refresh pulses", 1, ale_cnt);
      chk_cnt("refresh strobe", 2, rd_low);
      chk_val("back in halt", 20'h1, 20'(halted_o));
      leave_halt();
      $display("test plain halt done");
      // Idle then powerdown park; powerdown ignores hold and refresh
      for (int m = 0; m < 2; m++) begin
         idle_en_i      <= (m == 0);
         powerdown_en_i <= (m == 1);
         run(IHB_WR_MEM, 20'h8a5c3, 16'h1234);
         run(IHB_HALT, 20'h8a5c3, 16'h0);
         clr();
         refresh_req_i <= (m == 1);
         hold_req_i    <= (m == 1);
         repeat (8) @(negedge clk_i);
         chk_val("parked pins", 20'h000ff, pins);
         chk_val("parked bus", 20'h0ffff, {4'h0, muxed_addr_data_oe_o});
         chk_val("parked data", 20'h0, 20'(muxed_addr_data_o));
         chk_cnt("no wake", 0, ale_cnt);
         chk_val("still halted", 20'h2, 20'({halted_o, hold_ack_o}));
         @(posedge clk_i);
         refresh_req_i <= 1'b0;
         hold_req_i    <= 1'b0;
         leave_halt();
      end
      $display("test park done");
      give_verdict();
   end

   // Watchdog
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      give_verdict();
   end
endmodule

bind ihb_bus_unit ihb_bus_unit_assertions u_chk (.*);
